/* inc/deadband_pkg.sv */
// Shared constants and types for the dead-band and clock-phase control block
package deadband_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OUT_EN = 8'h04;
    localparam logic [7:0] ADDR_RISE_SRC = 8'h08;
    localparam logic [7:0] ADDR_MOD_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_RISE_TIME = 8'h10;
    localparam logic [7:0] ADDR_FALL_TIME = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // Clock control fields
    localparam int CLK_PRE_LSB = 4;
    localparam int CLK_SRC_LSB = 0;
    localparam logic [1:0] CLK_SRC_SYS = 2'h0;
    localparam logic [1:0] CLK_SRC_PLL = 2'h1;
    localparam logic [1:0] CLK_SRC_PIN = 2'h2;

    // Rising event source fields
    localparam int SRC_PIN_BIT = 7;
    localparam int SRC_C4_BIT = 4;
    localparam int SRC_TB_BIT = 0;

    // Modulator control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_COMP_BIT = 1;
    localparam int CTRL_BRIDGE_BIT = 2;
    localparam int CTRL_DBRE_BIT = 3;
    localparam int CTRL_DBFE_BIT = 4;
    localparam int CTRL_LOAD_BIT = 5;

    // Output enable masks for the full and the reduced instance
    localparam logic [5:0] OEN_MASK_FULL = 6'h3F;
    localparam logic [5:0] OEN_MASK_SECOND = 6'h03;

    localparam logic [7:0] COUNT_MAX = 8'hFF;

    // Gray codes along idle, rise count, primary on, fall count, complement on
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RISE_CNT = 3'h1,
        ST_PRI_ON = 3'h3,
        ST_FALL_CNT = 3'h2,
        ST_COMP_ON = 3'h6
    } db_state_t;

    typedef struct packed {
        logic [1:0] clk_pre;
        logic [1:0] clk_src;
        logic [5:0] oen;
        logic src_pin;
        logic src_c4;
        logic src_tb;
        logic enable;
        logic comp_mode;
        logic bridge_mode;
        logic rise_db_en;
        logic fall_db_en;
        logic load_req;
        logic [7:0] rise_time;
        logic [7:0] fall_time;
        logic [7:0] rise_active;
        logic [7:0] fall_active;
        db_state_t st;
        logic [7:0] cnt_r;
        logic [7:0] cnt_f;
        logic freeze;
        logic pri;
        logic comp;
        logic [2:0] pre_cnt;
        logic in_sync1;
        logic in_sync2;
        logic in_prev;
        logic ck_sync1;
        logic ck_sync2;
        logic ck_prev;
        logic c4_prev;
        logic match_prev;
        logic [31:0] rdata;
    } db_regs_t;

    localparam db_regs_t REGS_RESET = '0;

endpackage

/* rtl/deadband_ctrl.sv */
// Dead-band generator with clock, output enable and rising event source control
//
// Functional notes
// - Two independent 8-bit counters, one for rising, one for falling dead band.
// - Dead band only in complementary modes or on full-bridge direction change.
// - Rising event starts rising count; primary turns on after it ends.
// - Falling event starts falling count; complement turns on after it ends.
// - New rising time applies at first period event after load request.
// - New falling time applies at first period event after load request.
// - Each dead band has its own enable; enable changes act immediately.
// - Falling dead band has a dedicated enable bit separate from rising.
// - Both counters advance by one per modulator clock tick.
// - Asynchronous event sources may add up to one modulator clock of variation.
// - Falling event during rising count: switch to falling count, suppress primary.
// - Rising event during falling count: switch to rising count, suppress complement.
// - Same-direction event restarts count; outputs frozen until restarted count ends.
// - Source field bits 1-0: system clock, PLL clock, clock pin, reserved.
// - Output enable bits 5-0 hand each pin to the modulator when set.
// - Second instance lacks enables for outputs C to F.
// - Source bit 7 makes input pin going true a rising event.
// - Source bit 0 makes time base equal to phase a rising event.
// - Enabled rising event sources combine as alternatives.
`timescale 1ns/1ps

module deadband_ctrl #(
    parameter bit SECOND_INSTANCE = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_clk_tick,
    input wire logic modulator_clock_pin,
    input wire logic modulator_input_pin,
    input wire logic synced_comparator4_output,
    input wire logic [7:0] modulator_time_base,
    input wire logic [7:0] phase_value,
    input wire logic fall_edge_event,
    input wire logic period_event,
    input wire logic direction_changing,
    output logic [5:0] pwm_out,
    output logic [5:0] pwm_pin_select
);

    deadband_pkg::db_regs_t cur_reg;
    deadband_pkg::db_regs_t cur_next;

    logic [5:0] oen_mask;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic src_tick;
    logic [2:0] pre_mask;
    logic mod_tick;
    logic tb_match;
    logic pin_rise;
    logic ck_rise;
    logic c4_rise;
    logic db_allowed;
    logic rise_db_on;
    logic fall_db_on;
    logic rise_ev;
    logic fall_ev;
    logic rise_done;
    logic fall_done;

    assign oen_mask = SECOND_INSTANCE ? deadband_pkg::OEN_MASK_SECOND
                                      : deadband_pkg::OEN_MASK_FULL;

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_ok = (paddr == deadband_pkg::ADDR_CLK_CTRL) ||
                     (paddr == deadband_pkg::ADDR_OUT_EN) ||
                     (paddr == deadband_pkg::ADDR_RISE_SRC) ||
                     (paddr == deadband_pkg::ADDR_MOD_CTRL) ||
                     (paddr == deadband_pkg::ADDR_RISE_TIME) ||
                     (paddr == deadband_pkg::ADDR_FALL_TIME) ||
                     (paddr == deadband_pkg::ADDR_STATUS);

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = cur_reg.rdata;

    // Clock pin and input pin reach logic only through two flops and an edge register
    assign ck_rise = cur_reg.ck_sync2 && !cur_reg.ck_prev;
    assign pin_rise = cur_reg.in_sync2 && !cur_reg.in_prev;

    // Reserved source selection gives no ticks at all
    assign src_tick = (cur_reg.clk_src == deadband_pkg::CLK_SRC_SYS) ? 1'b1 :
                      (cur_reg.clk_src == deadband_pkg::CLK_SRC_PLL) ? pll_clk_tick :
                      (cur_reg.clk_src == deadband_pkg::CLK_SRC_PIN) ? ck_rise : 1'b0;
    assign pre_mask = 3'((4'h1 << cur_reg.clk_pre) - 4'h1);
    assign mod_tick = src_tick && ((cur_reg.pre_cnt & pre_mask) == pre_mask);

    assign tb_match = (modulator_time_base == phase_value);
    assign c4_rise = synced_comparator4_output && !cur_reg.c4_prev;

    assign rise_ev = cur_reg.enable &&
                     ((cur_reg.src_pin && pin_rise) ||
                      (cur_reg.src_c4 && c4_rise) ||
                      (cur_reg.src_tb && tb_match && !cur_reg.match_prev));
    assign fall_ev = cur_reg.enable && fall_edge_event;

    assign db_allowed = cur_reg.comp_mode ||
                        (cur_reg.bridge_mode && direction_changing);
    assign rise_db_on = db_allowed && cur_reg.rise_db_en;
    assign fall_db_on = db_allowed && cur_reg.fall_db_en;

    assign rise_done = !rise_db_on || (cur_reg.cnt_r >= cur_reg.rise_active);
    assign fall_done = !fall_db_on || (cur_reg.cnt_f >= cur_reg.fall_active);

    // Pins A, C, E carry the primary drive and B, D, F the complement
    assign pwm_pin_select = cur_reg.oen & oen_mask;
    assign pwm_out = {cur_reg.comp, cur_reg.pri, cur_reg.comp, cur_reg.pri,
                      cur_reg.comp, cur_reg.pri} & pwm_pin_select;

    always_comb begin
        cur_next = cur_reg;

        cur_next.in_sync1 = modulator_input_pin;
        cur_next.in_sync2 = cur_reg.in_sync1;
        cur_next.in_prev = cur_reg.in_sync2;
        cur_next.ck_sync1 = modulator_clock_pin;
        cur_next.ck_sync2 = cur_reg.ck_sync1;
        cur_next.ck_prev = cur_reg.ck_sync2;
        cur_next.c4_prev = synced_comparator4_output;
        cur_next.match_prev = tb_match;

        if (src_tick) begin
            cur_next.pre_cnt = cur_reg.pre_cnt + 3'h1;
        end

        // Shadow times move into the counters' compare values
        if (!cur_reg.enable) begin
            cur_next.rise_active = cur_reg.rise_time;
            cur_next.fall_active = cur_reg.fall_time;
        end else if (cur_reg.load_req && period_event) begin
            cur_next.rise_active = cur_reg.rise_time;
            cur_next.fall_active = cur_reg.fall_time;
            cur_next.load_req = 1'b0;
        end

        // Count running: counters step once per modulator tick
        if (cur_reg.st == deadband_pkg::ST_RISE_CNT && mod_tick &&
            cur_reg.cnt_r != deadband_pkg::COUNT_MAX) begin
            cur_next.cnt_r = cur_reg.cnt_r + 8'h01;
        end
        if (cur_reg.st == deadband_pkg::ST_FALL_CNT && mod_tick &&
            cur_reg.cnt_f != deadband_pkg::COUNT_MAX) begin
            cur_next.cnt_f = cur_reg.cnt_f + 8'h01;
        end

        // Falling event wins when both directions arrive in one cycle
        if (!cur_reg.enable) begin
            cur_next.st = deadband_pkg::ST_IDLE;
            cur_next.pri = 1'b0;
            cur_next.comp = 1'b0;
            cur_next.freeze = 1'b0;
            cur_next.cnt_r = 8'h00;
            cur_next.cnt_f = 8'h00;
        end else if (fall_ev) begin
            cur_next.cnt_f = 8'h00;
            cur_next.st = deadband_pkg::ST_FALL_CNT;
            if (cur_reg.st == deadband_pkg::ST_FALL_CNT) begin
                cur_next.freeze = 1'b1;
            end else begin
                cur_next.pri = 1'b0;
                cur_next.comp = 1'b0;
                cur_next.freeze = 1'b0;
                cur_next.cnt_r = 8'h00;
            end
        end else if (rise_ev) begin
            cur_next.cnt_r = 8'h00;
            cur_next.st = deadband_pkg::ST_RISE_CNT;
            if (cur_reg.st == deadband_pkg::ST_RISE_CNT) begin
                cur_next.freeze = 1'b1;
            end else begin
                cur_next.comp = 1'b0;
                cur_next.pri = 1'b0;
                cur_next.freeze = 1'b0;
                cur_next.cnt_f = 8'h00;
            end
        end else begin
            case (cur_reg.st)
                deadband_pkg::ST_RISE_CNT: begin
                    if (rise_done) begin
                        cur_next.st = deadband_pkg::ST_PRI_ON;
                        cur_next.pri = 1'b1;
                        cur_next.freeze = 1'b0;
                    end
                end
                deadband_pkg::ST_FALL_CNT: begin
                    if (fall_done) begin
                        cur_next.st = deadband_pkg::ST_COMP_ON;
                        cur_next.comp = 1'b1;
                        cur_next.freeze = 1'b0;
                    end
                end
                deadband_pkg::ST_IDLE,
                deadband_pkg::ST_PRI_ON,
                deadband_pkg::ST_COMP_ON: begin
                    cur_next.st = cur_reg.st;
                end
                default: begin
                    cur_next.st = deadband_pkg::ST_IDLE;
                    cur_next.pri = 1'b0;
                    cur_next.comp = 1'b0;
                end
            endcase
        end

        // Software write comes last so a written load request beats the clear
        if (wr_en) begin
            case (paddr)
                deadband_pkg::ADDR_CLK_CTRL: begin
                    cur_next.clk_pre = pwdata[deadband_pkg::CLK_PRE_LSB +: 2];
                    cur_next.clk_src = pwdata[deadband_pkg::CLK_SRC_LSB +: 2];
                end
                deadband_pkg::ADDR_OUT_EN: begin
                    cur_next.oen = pwdata[5:0] & oen_mask;
                end
                deadband_pkg::ADDR_RISE_SRC: begin
                    cur_next.src_pin = pwdata[deadband_pkg::SRC_PIN_BIT];
                    cur_next.src_c4 = pwdata[deadband_pkg::SRC_C4_BIT];
                    cur_next.src_tb = pwdata[deadband_pkg::SRC_TB_BIT];
                end
                deadband_pkg::ADDR_MOD_CTRL: begin
                    cur_next.enable = pwdata[deadband_pkg::CTRL_EN_BIT];
                    cur_next.comp_mode = pwdata[deadband_pkg::CTRL_COMP_BIT];
                    cur_next.bridge_mode = pwdata[deadband_pkg::CTRL_BRIDGE_BIT];
                    cur_next.rise_db_en = pwdata[deadband_pkg::CTRL_DBRE_BIT];
                    cur_next.fall_db_en = pwdata[deadband_pkg::CTRL_DBFE_BIT];
                    if (pwdata[deadband_pkg::CTRL_LOAD_BIT]) begin
                        cur_next.load_req = 1'b1;
                    end
                end
                deadband_pkg::ADDR_RISE_TIME: begin
                    cur_next.rise_time = pwdata[7:0];
                end
                deadband_pkg::ADDR_FALL_TIME: begin
                    cur_next.fall_time = pwdata[7:0];
                end
                default: begin
                    cur_next.rise_time = cur_next.rise_time;
                end
            endcase
        end

        // Read data is captured in the setup cycle and stands through the access
        if (rd_setup) begin
            case (paddr)
                deadband_pkg::ADDR_CLK_CTRL: begin
                    cur_next.rdata = {26'h0, cur_reg.clk_pre, 2'h0, cur_reg.clk_src};
                end
                deadband_pkg::ADDR_OUT_EN: begin
                    cur_next.rdata = {26'h0, cur_reg.oen};
                end
                deadband_pkg::ADDR_RISE_SRC: begin
                    cur_next.rdata = {24'h0, cur_reg.src_pin, 2'h0, cur_reg.src_c4,
                                      3'h0, cur_reg.src_tb};
                end
                deadband_pkg::ADDR_MOD_CTRL: begin
                    cur_next.rdata = {26'h0, cur_reg.load_req, cur_reg.fall_db_en,
                                      cur_reg.rise_db_en, cur_reg.bridge_mode,
                                      cur_reg.comp_mode, cur_reg.enable};
                end
                deadband_pkg::ADDR_RISE_TIME: begin
                    cur_next.rdata = {24'h0, cur_reg.rise_time};
                end
                deadband_pkg::ADDR_FALL_TIME: begin
                    cur_next.rdata = {24'h0, cur_reg.fall_time};
                end
                deadband_pkg::ADDR_STATUS: begin
                    cur_next.rdata = {8'h0, cur_reg.cnt_f, cur_reg.cnt_r, 2'h0,
                                      cur_reg.comp, cur_reg.pri, cur_reg.freeze,
                                      cur_reg.st};
                end
                default: begin
                    cur_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= deadband_pkg::REGS_RESET;
        end else begin
            cur_reg <= cur_next;
        end
    end

    a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
        !(cur_reg.pri && cur_reg.comp))
        else $error("primary and complement driven together");

    a_fall_over_rise: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.st == deadband_pkg::ST_RISE_CNT && fall_ev)
        |=> (cur_reg.st == deadband_pkg::ST_FALL_CNT && !cur_reg.pri && cur_reg.cnt_f == 8'h00))
        else $error("falling event did not take over rising count");

    a_rise_over_fall: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.st == deadband_pkg::ST_FALL_CNT && rise_ev && !fall_ev)
        |=> (cur_reg.st == deadband_pkg::ST_RISE_CNT && !cur_reg.comp && cur_reg.cnt_r == 8'h00))
        else $error("rising event did not take over falling count");

    a_repeat_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.st == deadband_pkg::ST_RISE_CNT && rise_ev && !fall_ev)
        |=> (cur_reg.freeze && $stable(cur_reg.pri) && $stable(cur_reg.comp)))
        else $error("repeated rising event did not freeze outputs");

    a_rise_hold_load: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.enable && !(cur_reg.load_req && period_event))
        |=> $stable(cur_reg.rise_active))
        else $error("rising time changed without a load");

    a_fall_hold_load: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.enable && cur_reg.load_req && period_event &&
         !(wr_en && paddr == deadband_pkg::ADDR_MOD_CTRL && pwdata[deadband_pkg::CTRL_LOAD_BIT]))
        |=> (cur_reg.fall_active == $past(cur_reg.fall_time) && !cur_reg.load_req))
        else $error("falling time not loaded at period event");

    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.st == deadband_pkg::ST_RISE_CNT && mod_tick && !rise_ev && !fall_ev &&
         cur_reg.enable && !rise_done && cur_reg.cnt_r != deadband_pkg::COUNT_MAX)
        |=> (cur_reg.cnt_r == $past(cur_reg.cnt_r) + 8'h01))
        else $error("rising counter did not step on tick");

    a_db_off_direct: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.enable && cur_reg.st == deadband_pkg::ST_FALL_CNT && !fall_db_on &&
         !rise_ev && !fall_ev)
        |=> (cur_reg.st == deadband_pkg::ST_COMP_ON && cur_reg.comp))
        else $error("disabled falling dead band still delayed complement");

    a_second_mask: assert property (@(posedge pclk) disable iff (!presetn)
        SECOND_INSTANCE |-> (pwm_pin_select[5:2] == 4'h0))
        else $error("absent output enables active on second instance");

    a_pin_event: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.enable && cur_reg.src_pin && pin_rise && !fall_ev)
        |=> (cur_reg.st == deadband_pkg::ST_RISE_CNT))
        else $error("input pin rise did not start rising count");

    a_div_eight: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_reg.clk_pre == 2'h3 && mod_tick) ##1 (cur_reg.clk_pre == 2'h3) |-> !mod_tick)
        else $error("divide by eight tick at wrong prescaler count");

endmodule // deadband_ctrl

/* tb/switch_driver_model.sv */
// Model of the external power switch drivers hanging on the modulator pins
`timescale 1ns/1ps
module switch_driver_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] pwm_out,
    input wire logic [5:0] pwm_pin_select,
    output logic shoot_through
);
    logic [5:0] drive;
    logic [2:0] both_on;
    // Only pins handed to the modulator reach the switch drivers
    assign drive = pwm_out & pwm_pin_select;
    // Primary and complement of one leg on together short the supply
    assign both_on = {drive[4] & drive[5], drive[2] & drive[3], drive[0] & drive[1]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shoot_through <= 1'b0;
        end else if (|both_on) begin
            shoot_through <= 1'b1;
        end
    end
endmodule // switch_driver_model

/* tb/pwm_deadband_clock_phase_tb.sv */
// Self-checking bench for dead-band, clock, output enable and rising source control
`timescale 1ns/1ps
module pwm_deadband_clock_phase_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, shoot_through;
    logic pll_clk_tick = 1'b0, modulator_clock_pin = 1'b0, modulator_input_pin = 1'b0;
    logic synced_comparator4_output = 1'b0, fall_edge_event = 1'b0, period_event = 1'b0;
    logic direction_changing = 1'b0, clk_pin_run = 1'b0;
    logic [7:0] modulator_time_base = 8'h00, phase_value = 8'h40;
    logic [5:0] pwm_out, pwm_pin_select, sel_second;
    logic [31:0] exp_q[$];
    int error_cnt = 0, samples_checked = 0, f, t, k;

    deadband_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pll_clk_tick(pll_clk_tick), .modulator_clock_pin(modulator_clock_pin),
        .modulator_input_pin(modulator_input_pin), .phase_value(phase_value),
        .synced_comparator4_output(synced_comparator4_output), .period_event(period_event),
        .modulator_time_base(modulator_time_base), .fall_edge_event(fall_edge_event),
        .direction_changing(direction_changing), .pwm_out(pwm_out),
        .pwm_pin_select(pwm_pin_select));
    deadband_ctrl #(.SECOND_INSTANCE(1'b1)) uut2 (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .pll_clk_tick(pll_clk_tick), .modulator_clock_pin(1'b0),
        .modulator_input_pin(1'b0), .phase_value(phase_value), .synced_comparator4_output(1'b0),
        .period_event(period_event), .modulator_time_base(modulator_time_base),
        .fall_edge_event(fall_edge_event), .direction_changing(direction_changing),
        .pwm_out(), .pwm_pin_select(sel_second));
    switch_driver_model drivers (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
        .pwm_pin_select(pwm_pin_select), .shoot_through(shoot_through));

    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        if (clk_pin_run) begin
            modulator_clock_pin <= ~modulator_clock_pin;
            pll_clk_tick <= ~pll_clk_tick;
        end
    end

    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wait_out();
        error_cnt++;
        $display("MISMATCH %0t: wait ran out", $time);
        test_done();
    endtask

    // Completed accesses check pslverr; completed reads are compared against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            chk(32'(pslverr), 32'(paddr > 8'h18));
            if (!pwrite) chk(prdata, exp_q.pop_front());
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) wait_out();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Fall event is a one-cycle pulse; rise event is a time base match onset
    task automatic ev(input bit fall);
        @(posedge pclk);
        if (fall) fall_edge_event <= 1'b1;
        else modulator_time_base <= phase_value;
        @(posedge pclk);
        fall_edge_event <= 1'b0;
        modulator_time_base <= 8'h00;
    endtask

    task automatic pulse_period();
        @(posedge pclk);
        period_event <= 1'b1;
        @(posedge pclk);
        period_event <= 1'b0;
    endtask

    // Counts edges from the event edge until the output turns on
    task automatic meas(input int b, input int lo, input int hi);
        int d;
        d = 0;
        do begin
            @(posedge pclk);
            #1;
            d++;
        end while (pwm_out[b] !== 1'b1 && d <= hi);
        if (pwm_out[b] !== 1'b1) begin
            wait_out();
        end else begin
            chk(32'((d >= lo && d <= hi) ? lo : d), 32'(lo));
        end
    endtask

    initial begin
        void'($urandom(71));
        f = 3 + ($urandom % 7);
        t = 4;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'h33);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'hFFFFFFFF);
        rd(8'h08, 32'h91);
        apb(1'b1, 8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h3F);
        rd(8'h40, 32'h0);
        chk(32'(pwm_pin_select), 32'h3F);
        chk(32'(sel_second), 32'h03);
        apb(1'b1, 8'h14, 32'(f));
        apb(1'b1, 8'h10, 32'(t));
        apb(1'b1, 8'h0C, 32'h1B);
        ev(1'b1);
        meas(1, f + 1, f + 1);
        ev(1'b0);
        meas(0, t + 1, t + 2);
        ev(1'b1);
        meas(1, f + 1, f + 1);
        @(posedge pclk);
        modulator_input_pin <= 1'b1;
        meas(0, t + 2, t + 6);
        ev(1'b0);
        ev(1'b1);
        meas(1, f + 1, f + 1);
        chk(32'(pwm_out[0]), 32'h0);
        ev(1'b1);
        ev(1'b0);
        meas(0, t + 1, t + 2);
        chk(32'(pwm_out[1]), 32'h0);
        ev(1'b1);
        ev(1'b1);
        meas(1, f + 1, f + 1);
        @(posedge pclk);
        synced_comparator4_output <= 1'b1;
        meas(0, t + 2, t + 2);
        apb(1'b1, 8'h14, 32'(f + 5));
        apb(1'b1, 8'h10, 32'(t + 3));
        pulse_period();
        ev(1'b1);
        meas(1, f + 1, f + 1);
        apb(1'b1, 8'h0C, 32'h3B);
        ev(1'b0);
        meas(0, t + 1, t + 2);
        pulse_period();
        ev(1'b1);
        meas(1, f + 6, f + 6);
        ev(1'b0);
        meas(0, t + 4, t + 5);
        apb(1'b1, 8'h0C, 32'h0B);
        ev(1'b1);
        meas(1, 1, 1);
        ev(1'b0);
        meas(0, t + 4, t + 5);
        apb(1'b1, 8'h0C, 32'h13);
        ev(1'b1);
        meas(1, f + 6, f + 6);
        ev(1'b0);
        meas(0, 1, 1);
        apb(1'b1, 8'h0C, 32'h19);
        ev(1'b1);
        ev(1'b0);
        meas(0, 1, 1);
        @(posedge pclk);
        direction_changing <= 1'b1;
        apb(1'b1, 8'h0C, 32'h1D);
        ev(1'b1);
        ev(1'b0);
        meas(0, t + 4, t + 5);
        apb(1'b1, 8'h0C, 32'h1B);
        for (int p = 0; p < 4; p++) begin
            k = 1 << p;
            apb(1'b1, 8'h00, 32'(p << 4));
            ev(1'b1);
            meas(1, (f + 4) * k + 2, (f + 5) * k + 1);
        end
        @(posedge pclk);
        clk_pin_run <= 1'b1;
        apb(1'b1, 8'h00, 32'h01);
        ev(1'b1);
        meas(1, 2 * f + 10, 2 * f + 11);
        apb(1'b1, 8'h00, 32'h02);
        ev(1'b1);
        meas(1, 2 * f + 9, 2 * f + 12);
        apb(1'b1, 8'h00, 32'h03);
        ev(1'b1);
        repeat (40) @(posedge pclk);
        chk(32'(pwm_out[1]), 32'h0);
        chk(32'(shoot_through), 32'h0);
        test_done();
    end
endmodule // pwm_deadband_clock_phase_tb
